// ==== hdl/papd_core.sv ====
// Protection and display selection logic of the process controller panel.
// Keys arrive as one-cycle pulses synchronous to clock; register port has no wait.
`timescale 1ns/1ns
`default_nettype none
module papd_core (
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire papd_pkg::papd_req_t req,
    output logic [31:0]            rdata,
    input  wire logic              key_change_by_event,
    input  wire logic              mask_loaded,
    input  wire logic              function_key,
    input  wire logic              mode_key,
    input  wire logic              key_edit,
    input  wire logic              param_init,
    input  wire logic              input_fault,
    input  wire logic signed [15:0] raw_value,
    input  wire logic [1:0]        sensor_dp,
    input  wire logic [15:0]       multi_sp,
    input  wire logic [15:0]       output_level,
    input  wire logic [15:0]       soak_remain,
    output logic                   function_key_act,
    output logic                   all_protect_indicator,
    output logic signed [15:0]     line1,
    output logic signed [15:0]     line2,
    output logic [15:0]            line3,
    output logic                   line2_blank,
    output logic                   line3_blank,
    output logic [1:0]             decimal_point,
    output logic                   input_error,
    output logic [2:0]             level
);
    // Settings
    logic [1:0]         op_prot;
    logic [1:0]         init_prot;
    logic               key_change_lock;
    logic               function_key_lock;
    logic               param_hide_enable;
    logic signed [15:0] protect_password_value;
    logic               pw_ok;
    logic signed [15:0] setpoint;
    logic signed [15:0] sp_lo;
    logic signed [15:0] sp_hi;
    logic [4:0]         input_type;
    logic [1:0]         analog_dp;
    logic signed [15:0] scale_lo;
    logic signed [15:0] scale_hi;
    logic               extra_pv;
    logic [2:0]         line3_sel;
    logic               second_screen;
    logic               err_latch;
    papd_pkg::papd_level_t cur_level;

    logic               wr_ok;
    logic               is_analog;
    logic signed [15:0] wd16;
    logic signed [31:0] span5;
    logic signed [31:0] pv_lo;
    logic signed [31:0] pv_hi;
    logic signed [15:0] pv;
    logic               lvl_allowed;

    // Clock and reset shared by the checks
    default clocking chk_cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    assign wd16 = req.wdata[15:0];
    // Key edits blocked by lock; protect-level settings stay writable
    assign wr_ok = req.wr && !(key_edit && key_change_lock);  // [R5]
    assign is_analog = input_type >= papd_pkg::ANALOG_MIN;

    // Protection settings, guarded by password
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            op_prot           <= papd_pkg::PROT_RST;
            init_prot         <= papd_pkg::PROT_RST;
            key_change_lock   <= 1'b0;
            function_key_lock <= 1'b0;
            param_hide_enable <= 1'b1;
        end else if (req.wr && (pw_ok || protect_password_value == papd_pkg::PW_NONE)) begin
            case (req.addr)  // [R12] [R26]
                papd_pkg::ADDR_OP_PROT:   op_prot <= req.wdata[1:0];
                papd_pkg::ADDR_INIT_PROT: begin
                    if (req.wdata[1:0] != 2'h3) begin
                        init_prot <= req.wdata[1:0];
                    end
                end
                papd_pkg::ADDR_KEY_LOCK: begin
                    if (!key_change_by_event) begin
                        key_change_lock <= req.wdata[0];  // [R7]
                    end
                end
                papd_pkg::ADDR_FKEY_LOCK: function_key_lock <= req.wdata[0];
                papd_pkg::ADDR_HIDE_EN: begin
                    if (mask_loaded) begin
                        param_hide_enable <= req.wdata[0];  // [R9]
                    end
                end
                default: ;
            endcase
        end
    end

    // Password store and entry check
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            protect_password_value <= papd_pkg::PW_NONE;  // [R10]
            pw_ok                  <= 1'b0;
        end else begin
            if (req.wr && req.addr == papd_pkg::ADDR_PASSWORD
                && (pw_ok || protect_password_value == papd_pkg::PW_NONE)
                && wd16 >= papd_pkg::PW_MIN && wd16 <= papd_pkg::PW_MAX) begin
                protect_password_value <= wd16;  // [R10] [R11]
            end
            if (req.wr && req.addr == papd_pkg::ADDR_PW_ENTRY) begin
                pw_ok <= (wd16 == protect_password_value);  // [R24] [R26]
            end else if (cur_level != papd_pkg::LVL_PROTECT) begin
                pw_ok <= 1'b0;
            end
        end
    end

    // Ordinary parameters, subject to key lock
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            setpoint   <= 16'sh0000;
            sp_lo      <= 16'sh8000;
            sp_hi      <= 16'sh7fff;
            input_type <= papd_pkg::INPUT_RST;  // [R17]
            analog_dp  <= 2'h0;
            scale_lo   <= 16'sh0000;
            scale_hi   <= 16'sh0064;
        end else if (wr_ok) begin
            case (req.addr)
                papd_pkg::ADDR_SETPOINT: begin
                    if (op_prot != 2'h3 && wd16 >= sp_lo && wd16 <= sp_hi) begin
                        setpoint <= wd16;  // [R3] [R19]
                    end
                end
                papd_pkg::ADDR_SP_LIMITS: begin
                    sp_lo <= wd16;
                    sp_hi <= $signed(req.wdata[31:16]);
                end
                papd_pkg::ADDR_INPUT_CFG: begin
                    input_type <= req.wdata[4:0];
                    analog_dp  <= req.wdata[9:8];
                end
                papd_pkg::ADDR_SCALE: begin
                    scale_lo <= wd16;
                    scale_hi <= $signed(req.wdata[31:16]);
                end
                default: ;
            endcase
        end
    end

    // Display configuration; initialization selects three-line view
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            extra_pv  <= 1'b0;
            line3_sel <= papd_pkg::SEL3_RST;  // [R22]
        end else if (param_init) begin
            line3_sel <= papd_pkg::SEL3_INIT;  // [R22]
        end else if (wr_ok && req.addr == papd_pkg::ADDR_DISP_CFG) begin
            extra_pv  <= req.wdata[4];
            line3_sel <= req.wdata[2:0];  // [R20]
        end
    end

    // Mode key toggles pair screens
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            second_screen <= 1'b0;
        end else if (line3_sel == 3'h1 || line3_sel == 3'h2
                     || line3_sel == 3'h5 || line3_sel == 3'h6) begin
            if (mode_key) begin
                second_screen <= !second_screen;  // [R21]
            end
        end else begin
            second_screen <= 1'b0;
        end
    end

    // Level requests checked against protection
    always_comb begin
        case (papd_pkg::papd_level_t'(req.wdata[2:0]))
            papd_pkg::LVL_OPER:    lvl_allowed = 1'b1;
            papd_pkg::LVL_ADJ:     lvl_allowed = (op_prot == 2'h0);  // [R1] [R2]
            papd_pkg::LVL_INIT:    lvl_allowed = op_prot < 2'h2 && init_prot < 2'h2;  // [R4]
            papd_pkg::LVL_COMM:    lvl_allowed = op_prot < 2'h2 && init_prot < 2'h2;  // [R4]
            papd_pkg::LVL_ADV:     lvl_allowed = op_prot < 2'h2 && init_prot == 2'h0;  // [R4]
            papd_pkg::LVL_PROTECT: lvl_allowed = 1'b1;
            default:               lvl_allowed = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cur_level <= papd_pkg::LVL_OPER;  // [R13]
        end else if (req.wr && req.addr == papd_pkg::ADDR_LEVEL_REQ && lvl_allowed) begin
            cur_level <= papd_pkg::papd_level_t'(req.wdata[2:0]);  // [R2] [R26]
        end
    end

    // Input error latches until power cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            err_latch <= 1'b0;
        end else if (input_fault || input_type > papd_pkg::INPUT_MAX) begin
            err_latch <= 1'b1;  // [R18]
        end
    end

    // Displayed value clamp
    assign span5 = ((32'(scale_hi) - 32'(scale_lo)) * papd_pkg::PCT_WIDEN) / 100;
    assign pv_lo = 32'(scale_lo) - span5;
    assign pv_hi = 32'(scale_hi) + span5;
    always_comb begin
        pv = raw_value;
        if (is_analog && 32'(raw_value) < pv_lo) begin
            pv = pv_lo[15:0];  // [R15]
        end else if (is_analog && 32'(raw_value) > pv_hi) begin
            pv = pv_hi[15:0];  // [R15]
        end
    end

    // Display outputs; hidden settings still act
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            line1         <= 16'sh0000;
            line2         <= 16'sh0000;
            line3         <= 16'h0000;
            line2_blank   <= 1'b1;
            line3_blank   <= 1'b1;
            decimal_point <= 2'h0;
        end else begin
            line1         <= pv;  // [R3]
            line2         <= setpoint;  // [R25]
            line2_blank   <= extra_pv;  // [R14]
            decimal_point <= is_analog ? analog_dp : sensor_dp;  // [R16]
            line3_blank   <= extra_pv || line3_sel == 3'h0;  // [R14] [R20]
            case (line3_sel)
                3'h1:    line3 <= second_screen ? output_level : multi_sp;
                3'h2:    line3 <= second_screen ? multi_sp : output_level;
                3'h3:    line3 <= multi_sp;
                3'h4:    line3 <= output_level;
                3'h5:    line3 <= second_screen ? soak_remain : multi_sp;
                3'h6:    line3 <= second_screen ? soak_remain : output_level;
                3'h7:    line3 <= soak_remain;
                default: line3 <= 16'h0000;
            endcase
        end
    end

    assign function_key_act      = function_key && !function_key_lock;  // [R8]
    assign all_protect_indicator = key_change_lock;  // [R6]
    assign input_error           = err_latch;
    assign level                 = cur_level;

    // Register read
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            case (req.addr)
                papd_pkg::ADDR_OP_PROT:   rdata <= (pw_ok ? {30'h0, op_prot} : 32'h0);  // [R24]
                papd_pkg::ADDR_INIT_PROT: rdata <= {30'h0, init_prot};
                papd_pkg::ADDR_KEY_LOCK:  rdata <= {31'h0, key_change_lock && !key_change_by_event};
                papd_pkg::ADDR_FKEY_LOCK: rdata <= {31'h0, function_key_lock};
                papd_pkg::ADDR_HIDE_EN:   rdata <= {31'h0, param_hide_enable && mask_loaded};
                papd_pkg::ADDR_PASSWORD:  rdata <= {{16{protect_password_value[15]}},
                                                    protect_password_value};
                papd_pkg::ADDR_SETPOINT:  rdata <= {{16{setpoint[15]}}, setpoint};
                papd_pkg::ADDR_SP_LIMITS: rdata <= {sp_hi, sp_lo};
                papd_pkg::ADDR_INPUT_CFG: rdata <= {22'h0, analog_dp, 3'h0, input_type};
                papd_pkg::ADDR_SCALE:     rdata <= {scale_hi, scale_lo};
                papd_pkg::ADDR_DISP_CFG:  rdata <= {27'h0, extra_pv, 1'b0, line3_sel};
                papd_pkg::ADDR_STATUS:    rdata <= {26'h0, second_screen, err_latch,
                                                    pw_ok, cur_level};
                default:                  rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // Checks
    a_indicator_follows: assert property (  // [R6]
        all_protect_indicator == key_change_lock)
        else $error("indicator wrong");
    a_fkey_blocked: assert property (  // [R8]
        function_key_lock |-> !function_key_act)
        else $error("fkey not blocked");
    a_adj_hidden: assert property (  // [R2]
        op_prot != 2'h0 |=> cur_level != papd_pkg::LVL_ADJ
            || $past(cur_level) == papd_pkg::LVL_ADJ)
        else $error("adjustment entered");
    a_adv_blocked: assert property (  // [R4]
        (cur_level != papd_pkg::LVL_ADV && init_prot != 2'h0)
            |=> cur_level != papd_pkg::LVL_ADV)
        else $error("advanced entered");
    a_sp_in_range: assert property (  // [R19]
        $changed(setpoint) |-> setpoint >= $past(sp_lo)
            && setpoint <= $past(sp_hi))
        else $error("setpoint out of range");
    a_err_sticky: assert property (  // [R18]
        err_latch |=> err_latch)
        else $error("error cleared");
    a_pw_range: assert property (  // [R10]
        protect_password_value >= papd_pkg::PW_MIN
            && protect_password_value <= papd_pkg::PW_MAX)
        else $error("password range");
    a_line3_none: assert property (  // [R20]
        line3_sel == 3'h0 |=> line3_blank)
        else $error("line3 shown");
    // Settings that must hold still
    a_sp_frozen: assert property (  // [R3]
        op_prot == 2'h3 |=> $stable(setpoint))
        else $error("setpoint moved");
    a_key_lock_edit: assert property (  // [R5]
        key_edit && key_change_lock |=> $stable(setpoint))
        else $error("locked edit");
    a_lock_by_event: assert property (  // [R7]
        key_change_by_event |=> $stable(key_change_lock))
        else $error("lock moved");
    a_hide_no_mask: assert property (  // [R9]
        !mask_loaded |=> $stable(param_hide_enable))
        else $error("hide moved");
    // Password gate on the protect settings, then extra process value line blanking
    a_prot_locked: assert property (  // [R12] [R26]
        protect_password_value != papd_pkg::PW_NONE && !pw_ok
            |=> $stable(op_prot) && $stable(init_prot))
        else $error("protect moved");
    a_pw_opens: assert property (  // [R24]
        req.wr && req.addr == papd_pkg::ADDR_PW_ENTRY
            && wd16 == protect_password_value |=> pw_ok)
        else $error("password refused");
    a_extra_pv_blank: assert property (  // [R14]
        extra_pv |=> line2_blank && line3_blank)
        else $error("lines shown");
endmodule // papd_core
`default_nettype wire

// ==== hdl/papd_pkg.sv ====
// Package for the panel access protection and display selection block.
// Assumes one 100 MHz clock and a simple strobe register port.
// How it works
// R1: Operation/adjustment protect 0 leaves operation and adjustment items open.
// R2: Protect 1 up hides adjustment; 2 and 3 also hide other operation items.
// R3: Process value always shown; setpoint editable at protect 0 to 2 only.
// R4: Initial/comms protect 0 all levels, 1 blocks advanced, 2 blocks all three.
// R5: Key lock on rejects key changes except protect-level settings.
// R6: All-protect indicator lit while key lock is on.
// R7: Key lock parameter hidden when an event input controls setting changes.
// R8: Function key lock on ignores the function key.
// R9: Parameter hide switch shown only when a mask is loaded.
// R10: Password is signed, -1999 to 9999, default 0 meaning none.
// R11: Operator changes password using increment or decrement with mode key.
// R12: With a password set, protection changes need the correct password.
// R13: After power-on the operation level is entered first.
// R14: Extra process value screen shows value on line one, blanks two and three.
// R15: Analog displayed value clamped to scaling limits widened by 5% of span.
// R16: Decimal point from sensor for temperature, from setting for analog.
// R17: Input type defaults to K thermocouple, code 5.
// R18: Bad input type shows an error, cleared only by correction and power cycle.
// R19: Setpoint entries accepted only within setpoint limits.
// R20: Third-line selector 0 to 7 picks none, single or alternating screens.
// R21: Selector 1, 2, 5 or 6: mode key toggles to the second screen.
// R22: Ships two-line; initializing parameters selects three-line display.
// R23: Operator holds mode and level keys three seconds for protect level.
// R24: Operation/adjustment protect shown only after the correct password.
// R25: Hidden protected parameters keep their values in effect.
// R26: Wrong password leaves level and all protection settings unchanged.
package papd_pkg;
    // Register offsets
    localparam logic [3:0] ADDR_OP_PROT    = 4'h0;
    localparam logic [3:0] ADDR_INIT_PROT  = 4'h1;
    localparam logic [3:0] ADDR_KEY_LOCK   = 4'h2;
    localparam logic [3:0] ADDR_FKEY_LOCK  = 4'h3;
    localparam logic [3:0] ADDR_HIDE_EN    = 4'h4;
    localparam logic [3:0] ADDR_PASSWORD   = 4'h5;
    localparam logic [3:0] ADDR_PW_ENTRY   = 4'h6;
    localparam logic [3:0] ADDR_SETPOINT   = 4'h7;
    localparam logic [3:0] ADDR_SP_LIMITS  = 4'h8;
    localparam logic [3:0] ADDR_INPUT_CFG  = 4'h9;
    localparam logic [3:0] ADDR_SCALE      = 4'ha;
    localparam logic [3:0] ADDR_DISP_CFG   = 4'hb;
    localparam logic [3:0] ADDR_STATUS     = 4'hc;
    localparam logic [3:0] ADDR_LEVEL_REQ  = 4'hd;
    // Reset values and limits
    localparam logic signed [15:0] PW_MIN      = 16'shf831;  // -1999
    localparam logic signed [15:0] PW_MAX      = 16'sh270f;  // 9999
    localparam logic signed [15:0] PW_NONE     = 16'sh0000;
    localparam logic [4:0]         INPUT_RST   = 5'h05;
    localparam logic [2:0]         SEL3_RST    = 3'h0;
    localparam logic [2:0]         SEL3_INIT   = 3'h1;
    localparam logic [1:0]         PROT_RST    = 2'h0;
    localparam logic [4:0]         ANALOG_MIN  = 5'h19;  // Codes 25 and up are analog
    localparam logic [4:0]         INPUT_MAX   = 5'h1c;
    localparam int                 PCT_WIDEN   = 5;
    // Level codes
    typedef enum logic [2:0] {
        LVL_OPER    = 3'h0,
        LVL_ADJ     = 3'h1,
        LVL_INIT    = 3'h2,
        LVL_COMM    = 3'h3,
        LVL_ADV     = 3'h4,
        LVL_PROTECT = 3'h5
    } papd_level_t;
    // Display screens
    typedef enum logic [1:0] {
        L3_NONE  = 2'h0,
        L3_MSP   = 2'h1,
        L3_MV    = 2'h2,
        L3_SOAK  = 2'h3
    } papd_line3_t;
    // Register request bundle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } papd_req_t;
endpackage

// ==== tb/panel_access_protection_display_test.sv ====
// Testbench: register accesses and key presses with expected port values.
// Assumes the register port answers one cycle after a read strobe.
`timescale 1ns/1ns
`default_nettype none
module panel_access_protection_display_test;
    logic                clock = 1'b0;
    logic                resetn = 1'b0;
    papd_pkg::papd_req_t req = '0;
    logic                want_fn = 1'b0, want_mode = 1'b0, key_edit = 1'b0;
    logic                key_change_by_event = 1'b0, mask_loaded = 1'b0;
    logic                param_init = 1'b0, input_fault = 1'b0;
    logic signed [15:0]  raw_value = 16'sh0000;
    logic [1:0]          sensor_dp = 2'h2;
    logic [31:0]         rdata;
    logic                function_key, mode_key, function_key_act, all_protect_indicator;
    logic signed [15:0]  line1, line2;
    logic [15:0]         line3;
    logic                line2_blank, line3_blank, input_error;
    logic [1:0]          decimal_point;
    logic [2:0]          level;
    int                  n_mismatch = 0;
    int                  checked = 0;
    // op protect, init protect, requested level, expected level
    logic [9:0]          lv_tab [8] = '{{2'h0, 2'h0, 3'h1, 3'h1}, {2'h1, 2'h0, 3'h1, 3'h0},
        {2'h2, 2'h0, 3'h2, 3'h0}, {2'h0, 2'h1, 3'h4, 3'h0}, {2'h0, 2'h1, 3'h2, 3'h2},
        {2'h0, 2'h2, 3'h2, 3'h0}, {2'h0, 2'h2, 3'h3, 3'h0}, {2'h0, 2'h0, 3'h4, 3'h4}};
    // Third-line selector and expected source value
    logic [18:0]         l3_tab [3] = '{{3'h3, 16'h1111}, {3'h4, 16'h2222}, {3'h7, 16'h3333}};

    papd_operator i_op (.clock(clock), .resetn(resetn), .want_fn(want_fn),
        .want_mode(want_mode), .function_key(function_key), .mode_key(mode_key));
    papd_core i_dut (.clock(clock), .resetn(resetn), .req(req), .rdata(rdata),
        .key_change_by_event(key_change_by_event), .mask_loaded(mask_loaded),
        .function_key(function_key), .mode_key(mode_key), .key_edit(key_edit),
        .param_init(param_init), .input_fault(input_fault), .raw_value(raw_value),
        .sensor_dp(sensor_dp), .multi_sp(16'h1111), .output_level(16'h2222),
        .soak_remain(16'h3333), .function_key_act(function_key_act),
        .all_protect_indicator(all_protect_indicator), .line1(line1), .line2(line2),
        .line3(line3), .line2_blank(line2_blank), .line3_blank(line3_blank),
        .decimal_point(decimal_point), .input_error(input_error), .level(level));

    // Free-running 100 MHz clock
    always #5 clock = ~clock;

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_half(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: port %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic ke = 1'b0);
        @(posedge clock);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        key_edit  <= ke;
        @(posedge clock);
        req.wr    <= 1'b0;
        key_edit  <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge clock);
        req.rd   <= 1'b0;
        #1;
        cmp_word(rdata, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Key held one cycle; returns while the key pulse stands
    task automatic press(input logic fn);
        @(posedge clock);
        if (fn) want_fn <= 1'b1;
        else want_mode <= 1'b1;
        @(posedge clock);
        want_fn   <= 1'b0;
        want_mode <= 1'b0;
        #1;
    endtask

    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clock);
        n_mismatch++;
        $display("ERROR %0t: run did not finish", $time);
        stop_test();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        idle(1);
        cmp_half({13'h0, level}, 16'h0);
        rd(papd_pkg::ADDR_INPUT_CFG, 32'h5);
        rd(papd_pkg::ADDR_DISP_CFG, 32'h0);
        foreach (lv_tab[i]) begin
            wr(papd_pkg::ADDR_OP_PROT, {30'h0, lv_tab[i][9:8]});
            wr(papd_pkg::ADDR_INIT_PROT, {30'h0, lv_tab[i][7:6]});
            wr(papd_pkg::ADDR_LEVEL_REQ, {29'h0, lv_tab[i][5:3]});
            idle(2);
            cmp_half({13'h0, level}, {13'h0, lv_tab[i][2:0]});
            wr(papd_pkg::ADDR_LEVEL_REQ, 32'h0);
        end
        // Setpoint limits, key lock and display-only setpoint
        wr(papd_pkg::ADDR_SP_LIMITS, {16'd100, 16'd0});
        wr(papd_pkg::ADDR_SETPOINT, 32'd50);
        rd(papd_pkg::ADDR_SETPOINT, 32'd50);
        idle(2);
        cmp_half(line2, 16'd50);
        wr(papd_pkg::ADDR_SETPOINT, 32'd200);
        rd(papd_pkg::ADDR_SETPOINT, 32'd50);
        wr(papd_pkg::ADDR_KEY_LOCK, 32'h1, 1'b1);
        idle(1);
        cmp_half({15'h0, all_protect_indicator}, 16'h1);
        wr(papd_pkg::ADDR_SETPOINT, 32'd60, 1'b1);
        rd(papd_pkg::ADDR_SETPOINT, 32'd50);
        wr(papd_pkg::ADDR_KEY_LOCK, 32'h0, 1'b1);
        idle(1);
        cmp_half({15'h0, all_protect_indicator}, 16'h0);
        wr(papd_pkg::ADDR_SETPOINT, 32'd60, 1'b1);
        rd(papd_pkg::ADDR_SETPOINT, 32'd60);
        wr(papd_pkg::ADDR_OP_PROT, 32'h3);
        wr(papd_pkg::ADDR_SETPOINT, 32'd70);
        rd(papd_pkg::ADDR_SETPOINT, 32'd60);
        wr(papd_pkg::ADDR_OP_PROT, 32'h0);
        key_change_by_event <= 1'b1;
        wr(papd_pkg::ADDR_KEY_LOCK, 32'h1);
        idle(1);
        cmp_half({15'h0, all_protect_indicator}, 16'h0);
        key_change_by_event <= 1'b0;
        // Function key lock
        press(1'b1);
        cmp_half({15'h0, function_key_act}, 16'h1);
        wr(papd_pkg::ADDR_FKEY_LOCK, 32'h1);
        press(1'b1);
        cmp_half({15'h0, function_key_act}, 16'h0);
        wr(papd_pkg::ADDR_FKEY_LOCK, 32'h0);
        // Parameter hide switch only reachable with a mask
        mask_loaded <= 1'b1;
        rd(papd_pkg::ADDR_HIDE_EN, 32'h1);
        wr(papd_pkg::ADDR_HIDE_EN, 32'h0);
        mask_loaded <= 1'b0;
        wr(papd_pkg::ADDR_HIDE_EN, 32'h1);
        mask_loaded <= 1'b1;
        rd(papd_pkg::ADDR_HIDE_EN, 32'h0);
        // Analog clamp: span 1000, widened by 50 each side
        raw_value <= 16'sd2000;
        wr(papd_pkg::ADDR_SCALE, {16'd1000, 16'd0});
        wr(papd_pkg::ADDR_INPUT_CFG, {22'h0, 2'h1, 3'h0, papd_pkg::ANALOG_MIN});
        idle(3);
        cmp_half(line1, 16'd1050);
        cmp_half({14'h0, decimal_point}, 16'h1);
        raw_value <= -16'sd500;
        idle(3);
        cmp_half(line1, 16'hffce);
        raw_value <= 16'sd100;
        wr(papd_pkg::ADDR_INPUT_CFG, 32'h5);
        idle(3);
        cmp_half({14'h0, decimal_point}, 16'h2);
        // Third display line
        foreach (l3_tab[i]) begin
            wr(papd_pkg::ADDR_DISP_CFG, {29'h0, l3_tab[i][18:16]});
            idle(3);
            cmp_half(line3, l3_tab[i][15:0]);
        end
        wr(papd_pkg::ADDR_DISP_CFG, 32'h1);
        idle(3);
        cmp_half(line3, 16'h1111);
        press(1'b0);
        idle(3);
        cmp_half(line3, 16'h2222);
        wr(papd_pkg::ADDR_DISP_CFG, 32'h0);
        idle(3);
        cmp_half({15'h0, line3_blank}, 16'h1);
        param_init <= 1'b1;
        idle(1);
        param_init <= 1'b0;
        rd(papd_pkg::ADDR_DISP_CFG, 32'h1);
        wr(papd_pkg::ADDR_DISP_CFG, 32'h10);
        idle(3);
        cmp_half({14'h0, line2_blank, line3_blank}, 16'h3);
        cmp_half(line1, 16'd100);
        // Latched input error
        input_fault <= 1'b1;
        idle(3);
        input_fault <= 1'b0;
        idle(3);
        cmp_half({15'h0, input_error}, 16'h1);
        // Password range, refusal without it, wrong then right entry
        wr(papd_pkg::ADDR_PASSWORD, 32'h2710);
        rd(papd_pkg::ADDR_PASSWORD, 32'h0);
        wr(papd_pkg::ADDR_PASSWORD, 32'h270f);
        rd(papd_pkg::ADDR_PASSWORD, 32'h270f);
        wr(papd_pkg::ADDR_INIT_PROT, 32'h2);
        rd(papd_pkg::ADDR_INIT_PROT, 32'h0);
        wr(papd_pkg::ADDR_LEVEL_REQ, {29'h0, papd_pkg::LVL_PROTECT});
        wr(papd_pkg::ADDR_PW_ENTRY, 32'h1);
        wr(papd_pkg::ADDR_INIT_PROT, 32'h2);
        rd(papd_pkg::ADDR_INIT_PROT, 32'h0);
        cmp_half({13'h0, level}, 16'h5);
        wr(papd_pkg::ADDR_PW_ENTRY, 32'h270f);
        wr(papd_pkg::ADDR_OP_PROT, 32'h1);
        rd(papd_pkg::ADDR_OP_PROT, 32'h1);
        wr(papd_pkg::ADDR_INIT_PROT, 32'h2);
        rd(papd_pkg::ADDR_INIT_PROT, 32'h2);
        stop_test();
    end
endmodule // panel_access_protection_display_test
`default_nettype wire

// ==== tb/papd_operator.sv ====
// Operator model: turns held key requests into one-cycle key pulses.
// Assumes the panel samples its keys on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module papd_operator (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic want_fn,
    input  wire logic want_mode,
    output logic      function_key,
    output logic      mode_key
);
    logic held_fn;
    logic held_mode;
    // One pulse per press however long held; combos are timed by the bench
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            {held_fn, held_mode, function_key, mode_key} <= 4'h0;
        end else begin
            held_fn      <= want_fn;
            held_mode    <= want_mode;
            function_key <= want_fn & ~held_fn;
            mode_key     <= want_mode & ~held_mode;
        end
    end
endmodule // papd_operator
`default_nettype wire
